// File: verilog/cefb_pkg.sv
// constants and carrier types for the converter event flag bank
package cefb_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PAIR_LOW    = 8'h19;
  localparam logic [7:0] ADDR_PAIR_HIGH   = 8'h1A;
  localparam logic [7:0] ADDR_THERM_LIVE  = 8'h1B;
  localparam logic [7:0] RESET_PAIR_LOW   = 8'h00;
  localparam logic [7:0] RESET_PAIR_HIGH  = 8'h00;
  localparam logic [7:0] RESET_THERM_LIVE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int NUM_CONV     = 4;
  localparam int FLAG_W       = 3;
  localparam int LOW_CONV_LSB = 0;
  localparam int HIGH_CONV_LSB = 4;
  localparam int THERM_SD_BIT = 3;
  localparam int THERM_WARN_BIT = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ    = 100;
  localparam int unsigned STARTUP_TIME_US = 1000;
  localparam int unsigned STARTUP_CYCLES  = STARTUP_TIME_US * CLK_FREQ_MHZ;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  // packing order puts power-good at bit 2, short at bit 1, limit at bit 0
  typedef struct packed {
    logic power_good;
    logic short_circuit;
    logic current_limit;
  } cefb_flags_t;

  // live analog indications of one converter core
  typedef struct packed {
    logic enabled;
    logic power_good;
    logic above_short_level;
    logic current_limit;
  } cefb_sense_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       rd;
  } cefb_reg_req_t;

endpackage : cefb_pkg

// File: verilog/cefb_event_flags.sv
// latched converter event flags and live thermal status registers
// Functional notes
// (R1) each converter sets a sticky power-good flag when its output first reaches threshold
// (R2) short flag sets whenever a running converter drops under 0.35 V
// (R3) short flag also sets when output misses 0.35 V within 1 ms of enable
// (R4) current-limit flag sets whenever the converter's limiter is engaged
// (R5) flags stay set until host writes one to that bit; clears only that flag
// (R6) converters 0/1 at 0x19, 2/3 at 0x1A; low conv bits 2:0, high 6:4
// (R7) bit 3 of 0x1B shows live thermal-shutdown comparator
// (R8) bit 2 of 0x1B shows live thermal-warning comparator
// (R9) thermal status is read-only; bits 7:4 and 1:0 read zero
// (R10) per-converter pending bit while any of its flags is set
// (R11) thermal-warning interrupt only while its mask bit is zero
// (R12) a set in the same cycle as a clear keeps the flag set
// (R13) flags and thermal bits zero after reset; reserved bit writes ignored
`timescale 1ns/1ps
`default_nettype none

module cefb_event_flags
  import cefb_pkg::*;
#(
  parameter int unsigned STARTUP_LIMIT = STARTUP_CYCLES
)(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  input  wire cefb_reg_req_t         REG_REQ,
  output logic [7:0]                 REG_RDATA,
  output logic                       REG_RVALID,
  input  wire cefb_sense_t [NUM_CONV-1:0] CONV_SENSE,
  input  wire logic                  OVERHEAT_SHUTDOWN_IN,
  input  wire logic                  OVERHEAT_WARNING_IN,
  input  wire logic                  OVERHEAT_WARNING_MASK,
  output logic [NUM_CONV-1:0]        CONV_PENDING,
  output logic                       OVERHEAT_WARNING_IRQ
);

  localparam int CNT_W = $clog2(STARTUP_LIMIT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_LIMIT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic cefb_flags_t clear_mask(input cefb_reg_req_t req, input int idx);
    logic [7:0] target;
    target = (idx < 2) ? ADDR_PAIR_LOW : ADDR_PAIR_HIGH;
    if (!req.wr || req.addr != target)
      return '0;
    // reserved bits 7 and 3 are never looked at
    return (idx % 2 == 1) ? req.wdata[HIGH_CONV_LSB +: FLAG_W]
                          : req.wdata[LOW_CONV_LSB +: FLAG_W];
  endfunction

  function automatic logic [7:0] pair_byte(input cefb_flags_t lo, input cefb_flags_t hi);
    return {1'b0, hi, 1'b0, lo};
  endfunction

  // -------------------------------------------------------------
  // start-up supervision
  // -------------------------------------------------------------
  cefb_flags_t [NUM_CONV-1:0] flag_reg;
  cefb_flags_t [NUM_CONV-1:0] flag_next;
  cefb_flags_t [NUM_CONV-1:0] set_vec;
  cefb_flags_t [NUM_CONV-1:0] clr_vec;
  logic [NUM_CONV-1:0][CNT_W-1:0] start_cnt_reg;
  logic [NUM_CONV-1:0]        starting_reg;
  logic [NUM_CONV-1:0]        running_reg;
  logic [NUM_CONV-1:0]        enabled_d_reg;
  logic [NUM_CONV-1:0]        pg_d_reg;
  logic [NUM_CONV-1:0]        timeout;
  logic                       therm_sd_reg;
  logic                       therm_warn_reg;
  logic                       warn_d_reg;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      start_cnt_reg <= '0;
      starting_reg  <= '0;
      running_reg   <= '0;
      enabled_d_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_CONV; i++)
      begin
        enabled_d_reg[i] <= CONV_SENSE[i].enabled;
        if (!CONV_SENSE[i].enabled)
        begin
          starting_reg[i] <= 1'b0;
          running_reg[i]  <= 1'b0;
        end
        else if (!enabled_d_reg[i])
        begin
          // fresh enable opens the start-up window
          starting_reg[i]  <= 1'b1;
          running_reg[i]   <= 1'b0;
          start_cnt_reg[i] <= CNT_ZERO;
        end
        else if (starting_reg[i])
        begin
          if (CONV_SENSE[i].above_short_level)
          begin
            starting_reg[i] <= 1'b0;
            running_reg[i]  <= 1'b1;
          end
          else if (timeout[i])
            starting_reg[i] <= 1'b0; // a failed start stays idle until re-enabled
          else
            start_cnt_reg[i] <= start_cnt_reg[i] + CNT_W'(1);
        end
      end
    end
  end

  // -------------------------------------------------------------
  // event flags
  // -------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_CONV; i++)
    begin
      timeout[i] = starting_reg[i] && !CONV_SENSE[i].above_short_level
                   && start_cnt_reg[i] == CNT_LAST; // R3
      set_vec[i].power_good    = CONV_SENSE[i].power_good && !pg_d_reg[i]; // R1
      set_vec[i].short_circuit = timeout[i]
                                 || (running_reg[i] && CONV_SENSE[i].enabled
                                     && !CONV_SENSE[i].above_short_level); // R2
      set_vec[i].current_limit = CONV_SENSE[i].current_limit; // R4
      clr_vec[i]   = clear_mask(REG_REQ, i); // R5
      flag_next[i] = set_vec[i] | (flag_reg[i] & ~clr_vec[i]); // R12
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      flag_reg     <= '0; // R13
      pg_d_reg     <= '0;
      CONV_PENDING <= '0;
    end
    else
    begin
      flag_reg <= flag_next;
      for (int i = 0; i < NUM_CONV; i++)
      begin
        pg_d_reg[i]     <= CONV_SENSE[i].power_good;
        CONV_PENDING[i] <= |flag_next[i]; // R10
      end
    end
  end

  // -------------------------------------------------------------
  // thermal status and warning interrupt
  // -------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      therm_sd_reg         <= 1'b0;
      therm_warn_reg       <= 1'b0;
      warn_d_reg           <= 1'b0;
      OVERHEAT_WARNING_IRQ <= 1'b0;
    end
    else
    begin
      therm_sd_reg   <= OVERHEAT_SHUTDOWN_IN; // R7
      therm_warn_reg <= OVERHEAT_WARNING_IN; // R8
      warn_d_reg     <= therm_warn_reg;
      // mask gates only the event, never the live bit
      OVERHEAT_WARNING_IRQ <= therm_warn_reg && !warn_d_reg && !OVERHEAT_WARNING_MASK; // R11
    end
  end

  // -------------------------------------------------------------
  // register read port
  // -------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd)
      begin
        case (REG_REQ.addr)
          ADDR_PAIR_LOW:   REG_RDATA <= pair_byte(flag_reg[0], flag_reg[1]); // R6
          ADDR_PAIR_HIGH:  REG_RDATA <= pair_byte(flag_reg[2], flag_reg[3]); // R6
          ADDR_THERM_LIVE:
          begin
            REG_RDATA <= 8'h00; // R9
            REG_RDATA[THERM_SD_BIT]   <= therm_sd_reg;
            REG_RDATA[THERM_WARN_BIT] <= therm_warn_reg;
          end
          default:         REG_RDATA <= READ_UNMAPPED;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  for (genvar g = 0; g < NUM_CONV; g++)
  begin : g_chk
    property p_pg_rise;
      CONV_SENSE[g].power_good && !pg_d_reg[g] |=> flag_reg[g].power_good;
    endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("power-good flag missed"); // R1

    property p_short_run;
      running_reg[g] && CONV_SENSE[g].enabled && !CONV_SENSE[g].above_short_level
        |=> flag_reg[g].short_circuit;
    endproperty
    a_short_run: assert property (p_short_run) else $error("short flag missed"); // R2

    property p_short_start;
      starting_reg[g] && start_cnt_reg[g] == CNT_LAST && !CONV_SENSE[g].above_short_level
        |=> flag_reg[g].short_circuit && !starting_reg[g];
    endproperty
    a_short_start: assert property (p_short_start) else $error("start timeout missed"); // R3

    property p_ilim;
      CONV_SENSE[g].current_limit |=> flag_reg[g].current_limit;
    endproperty
    a_ilim: assert property (p_ilim) else $error("limit flag missed"); // R4

    property p_hold;
      flag_reg[g].current_limit && !clr_vec[g].current_limit
        |=> flag_reg[g].current_limit;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped without clear"); // R5

    property p_clear;
      clr_vec[g].power_good && !set_vec[g].power_good |=> !flag_reg[g].power_good;
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear"); // R5

    property p_set_wins;
      clr_vec[g].current_limit && CONV_SENSE[g].current_limit |=> flag_reg[g].current_limit;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R12

    property p_pending;
      (|set_vec[g]) |=> CONV_PENDING[g];
    endproperty
    a_pending: assert property (p_pending) else $error("pending bit late"); // R10

    // pending must drop in the same cycle as the last flag, not one later
    property p_pending_clear;
      (flag_reg[g] & ~clr_vec[g]) == 3'h0 && set_vec[g] == 3'h0 |=> !CONV_PENDING[g];
    endproperty
    a_pending_clear: assert property (p_pending_clear) else $error("pending bit stuck"); // R10
  end

  property p_therm_read;
    REG_REQ.rd && REG_REQ.addr == ADDR_THERM_LIVE
      |=> REG_RVALID && REG_RDATA == {4'h0, $past(therm_sd_reg), $past(therm_warn_reg), 2'h0};
  endproperty
  a_therm_read: assert property (p_therm_read) else $error("thermal read wrong"); // R9

  property p_warn_mask;
    OVERHEAT_WARNING_MASK |=> !OVERHEAT_WARNING_IRQ;
  endproperty
  a_warn_mask: assert property (p_warn_mask) else $error("masked warning fired"); // R11

  // pair reads carry both converters of the pair, lower one in the low nibble
  property p_pair_low;
    REG_REQ.rd && REG_REQ.addr == ADDR_PAIR_LOW
      |=> REG_RDATA == {1'b0, $past(flag_reg[1]), 1'b0, $past(flag_reg[0])};
  endproperty
  a_pair_low: assert property (p_pair_low) else $error("low pair read wrong"); // R6

  property p_pair_high;
    REG_REQ.rd && REG_REQ.addr == ADDR_PAIR_HIGH
      |=> REG_RDATA == {1'b0, $past(flag_reg[3]), 1'b0, $past(flag_reg[2])};
  endproperty
  a_pair_high: assert property (p_pair_high) else $error("high pair read wrong"); // R6

  property p_reserved_read;
    REG_REQ.rd && REG_REQ.addr != ADDR_THERM_LIVE
      |=> !REG_RDATA[HIGH_CONV_LSB + FLAG_W] && !REG_RDATA[LOW_CONV_LSB + FLAG_W];
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit set"); // R13

  // the default disable would mute this one, so it opts out
  property p_reset_zero;
    disable iff (1'b0)
    RST |=> flag_reg == '0 && CONV_PENDING == '0 && !REG_RVALID && !OVERHEAT_WARNING_IRQ;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state left after reset"); // R13

endmodule // cefb_event_flags

`default_nettype wire

// File: dv/cefb_host_model.sv
// host-side model that issues register requests to the flag bank
`timescale 1ns/1ps
`default_nettype none

module cefb_host_model
  import cefb_pkg::*;
(
  input  wire logic           SYS_CLK,
  output var  cefb_reg_req_t  REG_REQ
);
  // ---------------------------------------------------------------
  // request driver
  // ---------------------------------------------------------------
  initial REG_REQ = '0;

  // one-cycle strobe launched at a falling edge, taken at the next rising edge;
  // released data is inverted so a stale value can never look valid
  task automatic access(input logic [7:0] addr, input logic is_wr, input logic [7:0] data);
    @(negedge SYS_CLK);
    REG_REQ = '{addr, is_wr, data, !is_wr};
    @(negedge SYS_CLK);
    REG_REQ = '{8'h00, 1'b0, ~data, 1'b0};
  endtask
endmodule // cefb_host_model

`default_nettype wire

// File: dv/converter_event_flag_bank_test.sv
// self-checking testbench for the converter event flag bank
`timescale 1ns/1ps
`default_nettype none

module converter_event_flag_bank_test;
  import cefb_pkg::*;
  // short start-up window keeps the failed-start case quick
  localparam int unsigned LIMIT = 20;

  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  cefb_reg_req_t              req;
  logic [7:0]                 rdata;
  logic                       rvalid;
  cefb_sense_t [NUM_CONV-1:0] sense = '0;
  logic                       sd = 1'b0;
  logic                       warn = 1'b0;
  logic                       mask = 1'b0;
  logic [NUM_CONV-1:0]        pending;
  logic                       irq;
  int                         mismatches = 0;
  int                         samples_checked = 0;
  int                         irq_seen = 0;
  logic [7:0]                 expq[$];
  integer                     seed = 32'h93030220;
  logic [7:0]                 a;
  int                         sh;

  always #5 clk = ~clk;

  cefb_host_model host (.SYS_CLK(clk), .REG_REQ(req));

  cefb_event_flags #(.STARTUP_LIMIT(LIMIT)) DUT (
    .SYS_CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .CONV_SENSE(sense), .OVERHEAT_SHUTDOWN_IN(sd), .OVERHEAT_WARNING_IN(warn),
    .OVERHEAT_WARNING_MASK(mask), .CONV_PENDING(pending), .OVERHEAT_WARNING_IRQ(irq)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    expq.push_back(exp);
    host.access(addr, 1'b0, 8'h00);
    tick(1);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host.access(addr, 1'b1, data);
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // output monitor
  // ---------------------------------------------------------------
  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
      check("read data", (expq.size() > 0) ? expq.pop_front() : 8'hXX, rdata);
    if (irq === 1'b1)
      irq_seen++;
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    fork
      begin
        #200000;
        mismatches++;
        give_verdict();
      end
    join_none
    tick(10);
    rst = 1'b0;
    rd(ADDR_PAIR_LOW, RESET_PAIR_LOW);
    rd(ADDR_PAIR_HIGH, RESET_PAIR_HIGH);
    rd(ADDR_THERM_LIVE, RESET_THERM_LIVE);
    rd(8'h20, READ_UNMAPPED);
    for (int i = 0; i < NUM_CONV; i++)
    begin
      a = (i < 2) ? ADDR_PAIR_LOW : ADDR_PAIR_HIGH;
      sh = (i % 2) ? HIGH_CONV_LSB : LOW_CONV_LSB;
      sense[i].current_limit = 1'b1;
      tick(1);
      sense[i].current_limit = 1'b0;
      tick(1);
      rd(a, 8'h01 << sh);
      check("pending", 8'(4'b0001 << i), 8'(pending));
      sense[i] = cefb_sense_t'(4'b1110);
      tick(3);
      sense[i].above_short_level = 1'b0;
      tick(2);
      sense[i] = '0;
      tick(2);
      rd(a, 8'h07 << sh);
      // limiter still engaged while the host clears its flag
      sense[i].current_limit = 1'b1;
      wr(a, 8'h01 << sh);
      sense[i].current_limit = 1'b0;
      rd(a, 8'h07 << sh);
      wr(a, (8'h06 << sh) | 8'h88);
      rd(a, 8'h01 << sh);
      wr(a, 8'h01 << sh);
      rd(a, 8'h00);
      check("pending", 8'h00, 8'(pending));
      sense[i].enabled = 1'b1;
      // first read lands on the edge that closes the window, so it still sees the flag clear
      tick(LIMIT - 1);
      rd(a, 8'h00);
      rd(a, 8'h02 << sh);
      sense[i] = '0;
      wr(a, 8'h02 << sh);
      rd(a, 8'h00);
    end
    // a reset in mid-run must drop flags that are already latched
    for (int i = 0; i < NUM_CONV; i++)
    begin
      sense[i].current_limit = 1'b1;
    end
    tick(1);
    sense = '0;
    tick(1);
    check("pending", 8'h0F, 8'(pending));
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    rd(ADDR_PAIR_LOW, RESET_PAIR_LOW);
    rd(ADDR_PAIR_HIGH, RESET_PAIR_HIGH);
    check("pending", 8'h00, 8'(pending));
    sd = 1'b1;
    warn = 1'b1;
    mask = 1'b1;
    tick(4);
    check("irq count", 8'h00, 8'(irq_seen));
    wr(ADDR_THERM_LIVE, 8'($random(seed)));
    wr(8'h30, 8'($random(seed)));
    rd(ADDR_THERM_LIVE, 8'h0C);
    warn = 1'b0;
    mask = 1'b0;
    tick(2);
    warn = 1'b1;
    tick(4);
    check("irq count", 8'h01, 8'(irq_seen));
    sd = 1'b0;
    tick(2);
    rd(ADDR_THERM_LIVE, 8'h04);
    warn = 1'b0;
    tick(2);
    rd(ADDR_THERM_LIVE, 8'h00);
    tick(4);
    check("reads outstanding", 8'h00, 8'(expq.size()));
    give_verdict();
  end
endmodule // converter_event_flag_bank_test

`default_nettype wire
